// ---- design/tmx_pkg.sv ----
/*
 * tmx_pkg: constants for the prescaled reload timer.
 * Assumes a plain register port with byte-wide registers.
 */
package tmx_pkg;
    localparam int TMX_AW = 8;
    // register offsets
    localparam logic [7:0] TMX_MODE_ADDR = 8'h8b;
    localparam logic [7:0] TMX_PRE_ADDR = 8'h8c;
    localparam logic [7:0] TMX_TMR_ADDR = 8'h8d;
    localparam logic [7:0] TMX_SRC_ADDR = 8'h8e;
    localparam logic [7:0] TMX_STAT_ADDR = 8'h8f;
    localparam logic [7:0] TMX_MASK_ADDR = 8'h90;
    localparam logic [7:0] TMX_MODE_RST = 8'h00;
    localparam logic [7:0] TMX_RLD_RST = 8'hff;
    // mode register fields
    localparam int TMX_MOD0_BIT = 0;
    localparam int TMX_MOD1_BIT = 1;
    localparam int TMX_POL_BIT = 3;
    localparam int TMX_START_BIT = 7;
    localparam int TMX_OCNT_BIT = 2;
    localparam int TMX_MOD2_BIT = 4;
    // status bits
    localparam int TMX_ST_UNF = 0;
    localparam int TMX_ST_EDGE = 1;
    // mode encodings {mod2, mod1, mod0}
    localparam logic [2:0] TMX_M_TIMER = 3'h0;
    localparam logic [2:0] TMX_M_PULSE = 3'h1;
    localparam logic [2:0] TMX_M_EVENT = 3'h2;
    localparam logic [2:0] TMX_M_WIDTH = 3'h3;
    localparam logic [2:0] TMX_M_PERIOD = 3'h4;
    // count source select
    localparam logic [1:0] TMX_SRC_F1 = 2'h0;
    localparam logic [1:0] TMX_SRC_F2 = 2'h1;
    localparam logic [1:0] TMX_SRC_F8 = 2'h2;
    localparam logic [1:0] TMX_SRC_RING = 2'h3;
    localparam logic [2:0] TMX_DIV8_LAST = 3'h7;
    typedef enum logic [3:0] {
        TMX_WR_IDLE = 4'b0001,
        TMX_WR_RLD = 4'b0010,
        TMX_WR_CNT = 4'b0100,
        TMX_WR_RUN = 4'b1000
    } tmx_wr_t;
endpackage

// ---- design/tmx_timer.sv ----
/*
 * tmx_timer: 8-bit down timer fed by an 8-bit prescaler, with reload,
 * start flag, count sources, pin modes and a masked interrupt.
 * Assumes one clock, synchronous reset, and pins from another domain.
 */
// Function
// - eight-bit down timer stage clocked by a separate eight-bit prescaler.
// - each stage has reload register and counter at one shared address.
// - internal source is sys clock divided by 1, 2, 8, or ring clock.
// - both stages decrement, reload on underflow and keep counting.
// - source to timer underflow division is (n+1)(m+1).
// - writing one to the start flag starts counting.
// - writing zero to the start flag stops, holding counter values.
// - every timer underflow raises the timer interrupt request.
// - reading a stage address returns that stage's counter value, except the timer returns the captured count in period mode.
// - write while stopped loads reload register and counter together.
// - write while counting: reload, then counter, resume at third input.
// - mode bits both zero select timer or period measurement mode.
// - polarity bit zero selects rising edge, one selects falling edge.
// - timer mode: count pin is I/O or external interrupt input.
// - five modes: timer, pulse, event, width and period measurement.
// - pulse output mode toggles the output pin on each timer underflow.
// - event counter mode counts active edges on the count pin.
// - measurement modes measure width or period of a pin pulse.
`timescale 1ns/10ps
module tmx_timer
    import tmx_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [TMX_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ring_oscillator_clock,
    input wire logic event_io_pin_in,
    output logic event_io_pin_out,
    output logic event_io_pin_oe,
    output logic event_io_inv_out,
    output logic event_io_inv_oe,
    output logic external_irq_one,
    output logic timer_irq,
    output logic irq
);
    // only the byte-wide datapath is built
    if (WIDTH != 8) begin : g_width_chk
        $error("tmx_timer supports only an 8-bit datapath");
    end

    logic [7:0] timer_mode_control_ff;
    logic [1:0] src_sel_ff;
    logic [7:0] pre_rld_ff, pre_cnt_ff, tmr_rld_ff, tmr_cnt_ff;
    logic [1:0] stat_ff, mask_ff;
    logic [7:0] rdata_ff;
    logic [2:0] div_ff;
    logic [2:0] ring_sync_ff, pin_sync_ff;
    logic ring_lvl_ff, pin_lvl_ff;
    logic out_ff, irq1_ff, tirq_ff;
    logic [7:0] pend_pre_ff, pend_tmr_ff;
    logic pend_pre_v_ff, pend_tmr_v_ff;
    tmx_wr_t wr_state_ff, nxt_wr_state;

    logic count_start_flag, polarity_switch;
    logic op_mode_select_low, op_mode_select_high;
    logic [2:0] mode;
    logic src_tick, pre_unf, tmr_unf, tick_ok;
    logic pin_rise, pin_fall, pin_edge, pin_level_active;
    logic wr_pre, wr_tmr, wr_any;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    assign count_start_flag = timer_mode_control_ff[TMX_START_BIT];
    assign polarity_switch = timer_mode_control_ff[TMX_POL_BIT];
    assign op_mode_select_low = timer_mode_control_ff[TMX_MOD0_BIT];
    assign op_mode_select_high = timer_mode_control_ff[TMX_MOD1_BIT];
    // mod bits 0 0 give timer or period; mod2 tells them apart
    assign mode = {timer_mode_control_ff[TMX_MOD2_BIT],
                   op_mode_select_high, op_mode_select_low};

    // synchronisers: compare only second and third stages
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ring_sync_ff <= 3'h0;
            pin_sync_ff <= 3'h0;
            ring_lvl_ff <= 1'b0;
            pin_lvl_ff <= 1'b0;
        end else begin
            ring_sync_ff <= {ring_sync_ff[1:0], ring_oscillator_clock};
            pin_sync_ff <= {pin_sync_ff[1:0], event_io_pin_in};
            if (ring_sync_ff[1] == ring_sync_ff[2]) begin
                ring_lvl_ff <= ring_sync_ff[2];
            end
            if (pin_sync_ff[1] == pin_sync_ff[2]) begin
                pin_lvl_ff <= pin_sync_ff[2];
            end
        end
    end

    logic ring_rise;
    assign ring_rise = (ring_sync_ff[1] == ring_sync_ff[2])
                       && ring_sync_ff[2] && !ring_lvl_ff;
    assign pin_rise = (pin_sync_ff[1] == pin_sync_ff[2])
                      && pin_sync_ff[2] && !pin_lvl_ff;
    assign pin_fall = (pin_sync_ff[1] == pin_sync_ff[2])
                      && !pin_sync_ff[2] && pin_lvl_ff;
    assign pin_edge = polarity_switch ? pin_fall : pin_rise;
    // width mode counts while the pin is at the chosen level
    assign pin_level_active = polarity_switch ? !pin_lvl_ff : pin_lvl_ff;

    // divider for f2 and f8
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end

    logic int_tick;
    always_comb begin
        case (src_sel_ff)
            TMX_SRC_F1: int_tick = 1'b1;
            TMX_SRC_F2: int_tick = div_ff[0];
            TMX_SRC_F8: int_tick = (div_ff == TMX_DIV8_LAST);
            TMX_SRC_RING: int_tick = ring_rise;
            default: int_tick = 1'b0;
        endcase
    end

    always_comb begin
        case (mode)
            TMX_M_EVENT: src_tick = pin_edge;
            TMX_M_WIDTH: src_tick = int_tick && pin_level_active;
            default: src_tick = int_tick;
        endcase
    end

    assign wr_pre = reg_wr && hit(reg_addr, TMX_PRE_ADDR);
    assign wr_tmr = reg_wr && hit(reg_addr, TMX_TMR_ADDR);
    assign wr_any = wr_pre || wr_tmr;
    // while a running write is pending the counters pause
    assign tick_ok = src_tick && count_start_flag
                     && (wr_state_ff == TMX_WR_IDLE
                         || wr_state_ff == TMX_WR_RUN);
    assign pre_unf = tick_ok && (pre_cnt_ff == 8'h00);
    assign tmr_unf = pre_unf && (tmr_cnt_ff == 8'h00);

    // period mode: an active edge arms a hold of the timer count at the
    // next prescaler underflow; the underflow after it reloads the timer
    typedef enum logic [2:0] {
        TMX_CAP_IDLE = 3'h1,
        TMX_CAP_ARM = 3'h2,
        TMX_CAP_HELD = 3'h4
    } tmx_cap_t;
    tmx_cap_t cap_state_ff;
    logic [7:0] cap_ff;
    logic per_mode, per_cap, per_rld, tmr_evt;

    assign per_mode = (mode == TMX_M_PERIOD);
    assign per_cap = per_mode && cap_state_ff == TMX_CAP_ARM && pre_unf;
    assign per_rld = per_mode && cap_state_ff == TMX_CAP_HELD && pre_unf;
    assign tmr_evt = tmr_unf || per_rld;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cap_state_ff <= TMX_CAP_IDLE;
        end else if (!per_mode || !count_start_flag) begin
            cap_state_ff <= TMX_CAP_IDLE;
        end else begin
            case (cap_state_ff)
                TMX_CAP_IDLE: begin
                    if (pin_edge) begin
                        cap_state_ff <= TMX_CAP_ARM;
                    end
                end
                TMX_CAP_ARM: begin
                    if (pre_unf) begin
                        cap_state_ff <= TMX_CAP_HELD;
                    end
                end
                TMX_CAP_HELD: begin
                    if (pre_unf) begin
                        cap_state_ff <= TMX_CAP_IDLE;
                    end
                end
                default: cap_state_ff <= TMX_CAP_IDLE;
            endcase
        end
    end

    // period-mode read-out buffer; software sees a steady value while the timer runs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cap_ff <= TMX_RLD_RST;
        end else if (per_cap) begin
            cap_ff <= tmr_cnt_ff;
        end
    end

    // mode register and software settings
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_mode_control_ff <= TMX_MODE_RST;
            src_sel_ff <= TMX_SRC_F1;
            mask_ff <= 2'h0;
        end else if (reg_wr) begin
            if (hit(reg_addr, TMX_MODE_ADDR)) begin
                timer_mode_control_ff <= reg_wdata;
            end
            if (hit(reg_addr, TMX_SRC_ADDR)) begin
                src_sel_ff <= reg_wdata[1:0];
            end
            if (hit(reg_addr, TMX_MASK_ADDR)) begin
                mask_ff <= reg_wdata[1:0];
            end
        end
    end

    // running-write sequencer: reload, counter, resume on source inputs
    always_comb begin
        nxt_wr_state = wr_state_ff;
        case (wr_state_ff)
            TMX_WR_IDLE: begin
                if (wr_any && count_start_flag) begin
                    nxt_wr_state = TMX_WR_RLD;
                end
            end
            TMX_WR_RLD: if (src_tick) nxt_wr_state = TMX_WR_CNT;
            TMX_WR_CNT: if (src_tick) nxt_wr_state = TMX_WR_RUN;
            TMX_WR_RUN: if (src_tick) nxt_wr_state = TMX_WR_IDLE;
            default: nxt_wr_state = TMX_WR_IDLE;
        endcase
        if (!count_start_flag) begin
            nxt_wr_state = TMX_WR_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_state_ff <= TMX_WR_IDLE;
        end else begin
            wr_state_ff <= nxt_wr_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pend_pre_ff <= TMX_RLD_RST;
            pend_tmr_ff <= TMX_RLD_RST;
            pend_pre_v_ff <= 1'b0;
            pend_tmr_v_ff <= 1'b0;
        end else if (wr_any && count_start_flag) begin
            if (wr_pre) begin
                pend_pre_ff <= reg_wdata;
                pend_pre_v_ff <= 1'b1;
            end
            if (wr_tmr) begin
                pend_tmr_ff <= reg_wdata;
                pend_tmr_v_ff <= 1'b1;
            end
        end else if (!count_start_flag
                     || (wr_state_ff == TMX_WR_RUN && src_tick)) begin
            // a stop drops pending values so no later write replays them
            pend_pre_v_ff <= 1'b0;
            pend_tmr_v_ff <= 1'b0;
        end
    end

    logic rld_step, cnt_step;
    assign rld_step = wr_state_ff == TMX_WR_RLD && src_tick;
    assign cnt_step = wr_state_ff == TMX_WR_CNT && src_tick;

    // prescaler stage
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pre_rld_ff <= TMX_RLD_RST;
            pre_cnt_ff <= TMX_RLD_RST;
        end else begin
            if (wr_pre && !count_start_flag) begin
                pre_rld_ff <= reg_wdata;
                pre_cnt_ff <= reg_wdata;
            end else if (rld_step && pend_pre_v_ff) begin
                pre_rld_ff <= pend_pre_ff;
            end else if (cnt_step && pend_pre_v_ff) begin
                pre_cnt_ff <= pre_rld_ff;
            end else if (pre_unf) begin
                pre_cnt_ff <= pre_rld_ff;
            end else if (tick_ok) begin
                pre_cnt_ff <= pre_cnt_ff - 8'h01;
            end
        end
    end

    // timer stage, decremented only by prescaler underflow
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tmr_rld_ff <= TMX_RLD_RST;
            tmr_cnt_ff <= TMX_RLD_RST;
        end else begin
            if (wr_tmr && !count_start_flag) begin
                tmr_rld_ff <= reg_wdata;
                tmr_cnt_ff <= reg_wdata;
            end else if (rld_step && pend_tmr_v_ff) begin
                tmr_rld_ff <= pend_tmr_ff;
            end else if (cnt_step && pend_tmr_v_ff) begin
                tmr_cnt_ff <= tmr_rld_ff;
            end else if (tmr_unf || per_rld) begin
                tmr_cnt_ff <= tmr_rld_ff;
            end else if (pre_unf) begin
                tmr_cnt_ff <= tmr_cnt_ff - 8'h01;
            end
        end
    end

    // pin outputs and interrupt pulses
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_ff <= 1'b0;
            irq1_ff <= 1'b0;
            tirq_ff <= 1'b0;
        end else begin
            tirq_ff <= tmr_evt;
            // timer mode: pin edge feeds the external interrupt
            irq1_ff <= pin_edge && (mode != TMX_M_PULSE);
            if (mode != TMX_M_PULSE || (wr_tmr && !count_start_flag)) begin
                out_ff <= polarity_switch; // start level
            end else if (tmr_unf) begin
                out_ff <= !out_ff;
            end
        end
    end

    assign timer_irq = tirq_ff;
    assign external_irq_one = irq1_ff;
    assign event_io_pin_out = out_ff;
    assign event_io_pin_oe = (mode == TMX_M_PULSE);
    assign event_io_inv_out = !out_ff;
    // inverted output only in pulse mode; otherwise a plain I/O
    assign event_io_inv_oe = (mode == TMX_M_PULSE)
                             && timer_mode_control_ff[TMX_OCNT_BIT];

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stat_ff <= 2'h0;
        end else begin
            if (reg_wr && hit(reg_addr, TMX_STAT_ADDR)) begin
                stat_ff <= stat_ff & ~reg_wdata[1:0];
            end
            if (tmr_evt) begin
                stat_ff[TMX_ST_UNF] <= 1'b1;
            end
            if (irq1_ff) begin
                stat_ff[TMX_ST_EDGE] <= 1'b1;
            end
        end
    end

    assign irq = |(stat_ff & mask_ff);

    // read data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                TMX_MODE_ADDR: rdata_ff <= timer_mode_control_ff;
                TMX_PRE_ADDR: rdata_ff <= pre_cnt_ff;
                TMX_TMR_ADDR: begin
                    rdata_ff <= per_mode ? cap_ff : tmr_cnt_ff;
                end
                TMX_SRC_ADDR: rdata_ff <= {6'h00, src_sel_ff};
                TMX_STAT_ADDR: rdata_ff <= {6'h00, stat_ff};
                TMX_MASK_ADDR: rdata_ff <= {6'h00, mask_ff};
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule

// ---- verification/tb.sv ----
/*
 * tb: register-level tests of the prescaled reload timer.
 * Assumes the register map and timings of tmx_pkg, f1 = sys_clk.
 */
`timescale 1ns/10ps
module tb
    import tmx_pkg::*;
;
`define CHK(a, e) \
    begin compares++; if ((a) !== (e)) begin failures++; \
    $display("Error at %0t: got %h exp %h", $time, a, e); end end
    logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic ring = 1'b0, pin = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, e;
    logic pin_out, pin_oe, inv_out, inv_oe, ext_irq, timer_irq, irq;
    int failures = 0, compares = 0, per, tc, ec, tl;
    tmx_timer dut_u (.sys_clk(sys_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ring_oscillator_clock(ring), .event_io_pin_in(pin),
        .event_io_pin_out(pin_out), .event_io_pin_oe(pin_oe),
        .event_io_inv_out(inv_out), .event_io_inv_oe(inv_oe),
        .external_irq_one(ext_irq), .timer_irq(timer_irq), .irq(irq));
    always #4 sys_clk = ~sys_clk;
    // odd half period keeps the ring clock out of phase with sys_clk
    always #41 ring = ~ring;
    always @(negedge sys_clk) begin
        if (timer_irq === 1'b1) tc++;
        if (ext_irq === 1'b1) ec++;
    end
    task results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask
    // cycles until the next timer interrupt pulse
    task wirq(output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (timer_irq !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            failures++;
            results;
        end
    endtask
    task pin_set(input logic v);
        @(posedge sys_clk);
        pin <= v;
        repeat (12) @(posedge sys_clk);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd(TMX_MODE_ADDR, d); `CHK(d, TMX_MODE_RST);
        rd(TMX_PRE_ADDR, d); `CHK(d, TMX_RLD_RST);
        rd(TMX_TMR_ADDR, d); `CHK(d, TMX_RLD_RST);
        rd(8'h00, d); `CHK(d, 8'h00);
        wr(TMX_PRE_ADDR, 8'h03);
        wr(TMX_TMR_ADDR, 8'h02);
        rd(TMX_PRE_ADDR, d); `CHK(d, 8'h03);
        rd(TMX_TMR_ADDR, d); `CHK(d, 8'h02);
        $display("test reset and stopped write done");
        for (int s = 0; s < 3; s++) begin
            wr(TMX_SRC_ADDR, 8'(s));
            wr(TMX_MODE_ADDR, 8'h80);
            wirq(per);
            wirq(per); `CHK(per, 12 * (s == 2 ? 8 : s + 1));
            wr(TMX_MODE_ADDR, 8'h00);
        end
        wr(TMX_PRE_ADDR, 8'h00);
        wr(TMX_TMR_ADDR, 8'h00);
        wr(TMX_SRC_ADDR, {6'h00, TMX_SRC_RING});
        wr(TMX_MODE_ADDR, 8'h80);
        wirq(per);
        wirq(per); `CHK(per >= 10 && per <= 11, 1'b1);
        wr(TMX_MODE_ADDR, 8'h00);
        wr(TMX_SRC_ADDR, {6'h00, TMX_SRC_F1});
        $display("test count sources done");
        wr(TMX_PRE_ADDR, 8'h03);
        wr(TMX_TMR_ADDR, 8'h09);
        wr(TMX_MODE_ADDR, 8'h80);
        repeat (20) @(posedge sys_clk);
        wr(TMX_MODE_ADDR, 8'h00);
        rd(TMX_TMR_ADDR, d); `CHK(d < 8'h09, 1'b1);
        repeat (30) @(posedge sys_clk);
        rd(TMX_TMR_ADDR, e); `CHK(e, d);
        wr(TMX_PRE_ADDR, 8'h00);
        wr(TMX_TMR_ADDR, 8'h02);
        wr(TMX_STAT_ADDR, 8'hff);
        rd(TMX_STAT_ADDR, d); `CHK(d, 8'h00);
        wr(TMX_MODE_ADDR, 8'h80);
        wirq(per);
        wirq(per); `CHK(per, 3);
        wr(TMX_TMR_ADDR, 8'h05);
        repeat (3) wirq(per);
        wirq(per); `CHK(per, 6);
        wr(TMX_MODE_ADDR, 8'h00);
        $display("test start stop reload done");
        rd(TMX_STAT_ADDR, d); `CHK(d, 8'h01);
        `CHK(irq, 1'b0);
        wr(TMX_MASK_ADDR, 8'h01);
        rd(TMX_MASK_ADDR, d); `CHK(d, 8'h01);
        `CHK(irq, 1'b1);
        wr(TMX_STAT_ADDR, 8'h01);
        rd(TMX_STAT_ADDR, d); `CHK(d, 8'h00);
        `CHK(irq, 1'b0);
        $display("test interrupt done");
        wr(TMX_TMR_ADDR, 8'h03);
        wr(TMX_MODE_ADDR, 8'h85);
        wirq(per);
        e = {7'h00, pin_out};
        wirq(per); `CHK(per, 4);
        `CHK(pin_out, ~e[0]);
        `CHK(inv_oe, 1'b1);
        `CHK(pin_oe, 1'b1);
        wr(TMX_MODE_ADDR, 8'h00);
        wr(TMX_TMR_ADDR, 8'h01);
        wr(TMX_MODE_ADDR, 8'h82);
        tc = 0;
        ec = 0;
        repeat (4) begin
            pin_set(1'b1);
            pin_set(1'b0);
        end
        `CHK(tc, 2);
        `CHK(ec, 4);
        `CHK(pin_oe, 1'b0);
        wr(TMX_MODE_ADDR, 8'h8a);
        ec = 0;
        pin_set(1'b1); `CHK(ec, 0);
        pin_set(1'b0); `CHK(ec, 1);
        $display("test pulse and event done");
        wr(TMX_MODE_ADDR, 8'h00);
        wr(TMX_TMR_ADDR, 8'h00);
        wr(TMX_MODE_ADDR, 8'h83);
        pin_set(1'b0);
        tc = 0;
        pin_set(1'b0);
        tl = tc;
        pin_set(1'b1);
        tc = 0;
        pin_set(1'b1);
        `CHK((tl == 0) != (tc == 0), 1'b1);
        $display("test width done");
        wr(TMX_MODE_ADDR, 8'h00);
        wr(TMX_TMR_ADDR, 8'h40);
        pin_set(1'b0);
        wr(TMX_MODE_ADDR, 8'h90);
        tc = 0;
        pin_set(1'b1); `CHK(tc, 1);
        rd(TMX_TMR_ADDR, d); `CHK(d > 8'h30 && d < 8'h40, 1'b1);
        repeat (10) @(posedge sys_clk);
        rd(TMX_TMR_ADDR, e); `CHK(e, d);
        $display("test period done");
        results;
    end
endmodule

// ---- verification/tmx_timer_properties.sv ----
/*
 * tmx_timer_chk: concurrent checks on the timer's ports.
 * Assumes one clock, sync active-high reset, bound to tmx_timer.
 */
`timescale 1ns/10ps
module tmx_timer_chk
    import tmx_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [TMX_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic event_io_pin_out,
    input wire logic event_io_pin_oe,
    input wire logic event_io_inv_out,
    input wire logic event_io_inv_oe,
    input wire logic timer_irq,
    input wire logic irq
);
    logic [7:0] mode_ff;
    logic [1:0] mask_ff;
    logic [2:0] age_ff;
    logic [2:0] stop_ff;
    logic pulse_m;
    assign pulse_m = {mode_ff[TMX_MOD2_BIT], mode_ff[TMX_MOD1_BIT],
        mode_ff[TMX_MOD0_BIT]} == TMX_M_PULSE;
    always_ff @(posedge sys_clk) begin
        if (reset)
            mode_ff <= TMX_MODE_RST;
        else if (reg_wr && reg_addr == TMX_MODE_ADDR)
            mode_ff <= reg_wdata;
    end
    always_ff @(posedge sys_clk) begin
        if (reset)
            mask_ff <= 2'h0;
        else if (reg_wr && reg_addr == TMX_MASK_ADDR)
            mask_ff <= reg_wdata[1:0];
    end
    // cycles since the last mode write, for settling of pin logic
    always_ff @(posedge sys_clk) begin
        if (reset || (reg_wr && reg_addr == TMX_MODE_ADDR))
            age_ff <= 3'h0;
        else if (age_ff != 3'h7)
            age_ff <= age_ff + 3'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (reset || mode_ff[TMX_START_BIT])
            stop_ff <= 3'h0;
        else if (stop_ff != 3'h7)
            stop_ff <= stop_ff + 3'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h00
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_MODE_RB: assert property (reg_rd && reg_addr == TMX_MODE_ADDR
        |=> (reg_rdata & 8'h9f) == ($past(mode_ff) & 8'h9f))
        else $error("mode readback wrong");
    AST_MASK_QUIET: assert property (mask_ff == 2'h0
        && $past(mask_ff) == 2'h0 |-> !irq) else $error("masked irq high");
    AST_IRQ_SETS: assert property (timer_irq && mask_ff[TMX_ST_UNF]
        |-> ##[0:2] irq) else $error("unmasked underflow gave no irq");
    AST_STOP_QUIET: assert property (stop_ff >= 3'h4 |-> !timer_irq)
        else $error("underflow while stopped");
    AST_PULSE_OE: assert property (pulse_m && age_ff >= 3'h3
        |-> event_io_pin_oe) else $error("pulse pin not driven");
    AST_IO_IDLE: assert property (!pulse_m && age_ff >= 3'h3
        |-> !event_io_pin_oe && !event_io_inv_oe)
        else $error("pin driven outside pulse mode");
    AST_INV: assert property (event_io_inv_oe
        |-> event_io_inv_out == !event_io_pin_out)
        else $error("inverted output not inverse");
    AST_PULSE_TOGGLE: assert property (pulse_m && age_ff >= 3'h3
        && timer_irq |-> event_io_pin_out != $past(event_io_pin_out))
        else $error("pulse output did not toggle on underflow");
endmodule

bind tmx_timer tmx_timer_chk #(.WIDTH(WIDTH)) chk_u (
    .sys_clk(sys_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .event_io_pin_out(event_io_pin_out),
    .event_io_pin_oe(event_io_pin_oe),
    .event_io_inv_out(event_io_inv_out),
    .event_io_inv_oe(event_io_inv_oe),
    .timer_irq(timer_irq),
    .irq(irq)
);
